/* logic/phase_divider.sv */
// Purpose: splits the system clock into four phases per instruction cycle
// Assumes: i_enable low freezes the phase
// Notes:   o_last marks the final phase of a cycle
`timescale 1ns/1ps
module phase_divider #(
  parameter int unsigned PHASES = 4
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_enable,
  output logic [$clog2(PHASES)-1:0]      o_phase,
  output logic                           o_last
);
  import seq_pkg::*;

  localparam logic [$clog2(PHASES)-1:0] LAST = ($clog2(PHASES))'(PHASES - 1);

  logic [$clog2(PHASES)-1:0] phase_reg;
  logic [$clog2(PHASES)-1:0] phase_next;

  generate
    if (PHASES < 2 || (PHASES & (PHASES - 1)) != 0)
    begin : g_bad
      $error("phase count must be a power of two of at least two");
    end
  endgenerate

  assign phase_next = (phase_reg == LAST) ? '0 : phase_reg + 1'b1;
  assign o_phase    = phase_reg;
  assign o_last     = (phase_reg == LAST);

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      phase_reg <= '0;
    else if (i_enable)
      phase_reg <= phase_next;
  end

  phase_wrap_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_enable && o_last |=> phase_reg == '0)
    else $error("phase did not wrap after the last phase");

endmodule : phase_divider

/* logic/program_counter_sequencer.sv */
// Purpose: program counter and fetch/execute sequencing of the core
// Assumes: i_pmem_data is valid by the last phase of the fetch cycle
// Notes:   AXI4-Lite slave holds control, status and the counter low byte
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module program_counter_sequencer #(
  parameter int unsigned PC_W    = 11,
  parameter int unsigned WORD_W  = 15,
  parameter int unsigned STARTUP = 1024
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_sys_rst,
  input  wire logic [7:0]                  i_s_axi_awaddr,
  input  wire logic [2:0]                  i_s_axi_awprot,
  input  wire logic                        i_s_axi_awvalid,
  output logic                             o_s_axi_awready,
  input  wire logic [31:0]                 i_s_axi_wdata,
  input  wire logic [3:0]                  i_s_axi_wstrb,
  input  wire logic                        i_s_axi_wvalid,
  output logic                             o_s_axi_wready,
  output logic [1:0]                       o_s_axi_bresp,
  output logic                             o_s_axi_bvalid,
  input  wire logic                        i_s_axi_bready,
  input  wire logic [7:0]                  i_s_axi_araddr,
  input  wire logic [2:0]                  i_s_axi_arprot,
  input  wire logic                        i_s_axi_arvalid,
  output logic                             o_s_axi_arready,
  output logic [31:0]                      o_s_axi_rdata,
  output logic [1:0]                       o_s_axi_rresp,
  output logic                             o_s_axi_rvalid,
  input  wire logic                        i_s_axi_rready,
  input  wire seq_pkg::xfer_kind_e         i_xfer_kind,
  input  wire logic [PC_W-1:0]             i_xfer_target,
  input  wire logic [WORD_W-1:0]           i_pmem_data,
  output logic [PC_W-1:0]                  o_pmem_addr,
  output logic                             o_pmem_rd,
  output logic [WORD_W-1:0]                o_exec_word,
  output logic                             o_exec_valid,
  output logic                             o_dummy_cycle,
  output logic [1:0]                       o_phase,
  output logic                             o_running
);
  import seq_pkg::*;

  generate
    if (PC_W != PC_WIDTH || WORD_W < 1)
    begin : g_bad
      $error("counter must be eleven bits and the word non-empty");
    end
  endgenerate

  seq_state_e       state_reg;
  logic [PC_W-1:0]  pc_reg;
  logic [PC_W-1:0]  pc_next;
  logic [WORD_W-1:0] exec_word_reg;
  logic             exec_valid_reg;
  logic             pmem_rd_reg;
  logic             hold_reg;
  logic             lowb_pend_reg;
  logic [7:0]       lowb_data_reg;
  logic             dummy_reg;
  logic             running_reg;
  logic             awready_reg;
  logic             bvalid_reg;
  logic [1:0]       bresp_reg;
  logic             arready_reg;
  logic             rvalid_reg;
  logic [1:0]       rresp_reg;
  logic [31:0]      rdata_reg;
  logic [7:0]       waddr_reg;
  logic [31:0]      wdata_reg;
  logic [3:0]       wstrb_reg;

  wire              started;
  wire [1:0]        phase;
  wire              phase_last;

  startup_timer #(
    .CYCLES (STARTUP)
  ) u_startup (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .o_done    (started)
  );

  wire divider_en = (state_reg == st_run) && !hold_reg;

  phase_divider #(
    .PHASES (PHASE_COUNT)
  ) u_phase (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_enable  (divider_en),
    .o_phase   (phase),
    .o_last    (phase_last)
  );

  // target address for a transfer, or the increment for none and skip
  function automatic logic [PC_W-1:0] target_of(
    input xfer_kind_e      kind,
    input logic [PC_W-1:0] tgt,
    input logic [PC_W-1:0] pc
  );
    case (kind)
      xfer_jump, xfer_call, xfer_ret, xfer_reti: target_of = tgt;
      xfer_irq_usb: target_of = USB_VECTOR;
      xfer_irq_t0:  target_of = TIMER0_VECTOR;
      xfer_irq_t1:  target_of = TIMER1_VECTOR;
      default:      target_of = pc + 1'b1;
    endcase
  endfunction : target_of

  // instruction transfers only act from a valid executing word
  function automatic logic kind_acts(input xfer_kind_e kind, input logic valid);
    case (kind)
      xfer_none:                                kind_acts = 1'b0;
      xfer_irq_usb, xfer_irq_t0, xfer_irq_t1:   kind_acts = 1'b1;
      default:                                  kind_acts = valid;
    endcase
  endfunction : kind_acts

  wire        boundary   = divider_en && phase_last;
  wire        start_now  = (state_reg == st_startup) && started;
  wire        xfer_act   = boundary && kind_acts(i_xfer_kind, exec_valid_reg);
  wire        lowb_apply = boundary && !xfer_act && lowb_pend_reg;
  wire        flush      = xfer_act || lowb_apply;
  wire [PC_W-1:0] lowb_target = {pc_reg[PC_W-1:8], lowb_data_reg};

  always_comb
  begin
    pc_next = pc_reg;
    if (xfer_act)
      pc_next = target_of(i_xfer_kind, i_xfer_target, pc_reg);
    else if (lowb_apply)
      pc_next = lowb_target;
    else if (boundary)
      pc_next = pc_reg + 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_reg      <= st_startup;
      pc_reg         <= RESET_VECTOR;
      exec_word_reg  <= '0;
      exec_valid_reg <= 1'b0;
      pmem_rd_reg    <= 1'b0;
      dummy_reg      <= 1'b1;
      running_reg    <= 1'b0;
    end
    else
    begin
      case (state_reg)
        st_startup: if (started) state_reg <= st_run;
        st_run:     state_reg <= st_run;
        default:    state_reg <= st_startup;
      endcase
      pc_reg      <= pc_next;
      pmem_rd_reg <= boundary || start_now;
      if (start_now)
        running_reg <= 1'b1;
      if (boundary)
      begin
        exec_word_reg  <= i_pmem_data;
        exec_valid_reg <= !flush;
        dummy_reg      <= flush;
      end
    end
  end

  // AXI4-Lite: write taken when address and data are both offered
  wire aw_take = i_s_axi_awvalid && i_s_axi_wvalid && !awready_reg && !bvalid_reg;
  wire w_done  = awready_reg;
  wire w_lowb  = w_done && waddr_reg == LOW_BYTE_ADDR;
  wire w_ctrl  = w_done && waddr_reg == CTRL_ADDR;
  wire w_ok    = w_lowb || w_ctrl;
  wire ar_take = i_s_axi_arvalid && !arready_reg && !rvalid_reg;

  wire [31:0] status_word = {29'h0, !exec_valid_reg && state_reg == st_run,
                             lowb_pend_reg, state_reg == st_run};
  wire        r_known = i_s_axi_araddr == LOW_BYTE_ADDR || i_s_axi_araddr == CTRL_ADDR
                     || i_s_axi_araddr == STATUS_ADDR || i_s_axi_araddr == PC_ADDR;
  wire [31:0] r_word  = (i_s_axi_araddr == LOW_BYTE_ADDR) ? {24'h0, pc_reg[7:0]} :
                        (i_s_axi_araddr == CTRL_ADDR)   ? {31'h0, hold_reg} :
                        (i_s_axi_araddr == STATUS_ADDR) ? status_word :
                        (i_s_axi_araddr == PC_ADDR)     ? {21'h0, pc_reg} : 32'h0;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      awready_reg  <= 1'b0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= RESP_OKAY;
      arready_reg  <= 1'b0;
      rvalid_reg   <= 1'b0;
      rresp_reg    <= RESP_OKAY;
      rdata_reg    <= 32'h0;
      waddr_reg    <= 8'h0;
      wdata_reg    <= 32'h0;
      wstrb_reg    <= 4'h0;
      hold_reg     <= 1'b0;
      lowb_pend_reg <= 1'b0;
      lowb_data_reg <= 8'h0;
    end
    else
    begin
      awready_reg <= aw_take;
      if (aw_take)
      begin
        waddr_reg <= {i_s_axi_awaddr[7:2], 2'b00};
        wdata_reg <= i_s_axi_wdata;
        wstrb_reg <= i_s_axi_wstrb;
      end
      if (w_done)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= w_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (i_s_axi_bready)
        bvalid_reg <= 1'b0;
      if (w_ctrl && wstrb_reg[0])
        hold_reg <= wdata_reg[CTRL_HOLD_BIT];
      // a new write in the applying cycle keeps the jump pending
      if (w_lowb && wstrb_reg[0])
      begin
        lowb_pend_reg <= 1'b1;
        lowb_data_reg <= wdata_reg[7:0];
      end
      else if (lowb_apply)
        lowb_pend_reg <= 1'b0;
      arready_reg <= ar_take;
      if (ar_take)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= r_word;
        rresp_reg  <= r_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (i_s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end

  assign o_s_axi_awready = awready_reg;
  assign o_s_axi_wready  = awready_reg;
  assign o_s_axi_bvalid  = bvalid_reg;
  assign o_s_axi_bresp   = bresp_reg;
  assign o_s_axi_arready = arready_reg;
  assign o_s_axi_rvalid  = rvalid_reg;
  assign o_s_axi_rresp   = rresp_reg;
  assign o_s_axi_rdata   = rdata_reg;
  assign o_pmem_addr     = pc_reg;
  assign o_pmem_rd       = pmem_rd_reg;
  assign o_exec_word     = exec_word_reg;
  assign o_exec_valid    = exec_valid_reg;
  assign o_dummy_cycle   = dummy_reg;
  assign o_phase         = phase;
  assign o_running       = running_reg;

  cycle_len_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    boundary ##1 !hold_reg[*4] |-> boundary && !$past(boundary, 1) && !$past(boundary, 2)
      && !$past(boundary, 3))
    else $error("instruction cycle is not four clocks");

  pc_incr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    boundary && !flush |=> pc_reg == $past(pc_reg) + 1'b1)
    else $error("counter did not advance by one");

  overlap_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    boundary && !flush |=> exec_valid_reg && exec_word_reg == $past(i_pmem_data))
    else $error("fetched word not passed to execute");

  xfer_dummy_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    xfer_act && i_xfer_kind inside {xfer_jump, xfer_call, xfer_ret, xfer_reti}
      |=> !exec_valid_reg && pc_reg == $past(i_xfer_target))
    else $error("transfer without dummy cycle or wrong target");

  skip_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    xfer_act && i_xfer_kind == xfer_skip |=> !exec_valid_reg && pc_reg == $past(pc_reg) + 1'b1)
    else $error("taken skip did not discard the prefetched word");

  lowb_jump_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    lowb_apply |=> pc_reg[10:8] == $past(pc_reg[10:8]) && pc_reg[7:0] == $past(lowb_data_reg)
      && !exec_valid_reg)
    else $error("low byte jump left the page or kept the prefetch");

  vector_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    xfer_act && i_xfer_kind == xfer_irq_t1 |=> pc_reg == TIMER1_VECTOR && !exec_valid_reg)
    else $error("timer 1 vector wrong");

  usb_vector_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    xfer_act && i_xfer_kind == xfer_irq_usb |=> pc_reg == USB_VECTOR && !exec_valid_reg)
    else $error("usb vector wrong");

  t0_vector_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    xfer_act && i_xfer_kind == xfer_irq_t0 |=> pc_reg == TIMER0_VECTOR && !exec_valid_reg)
    else $error("timer 0 vector wrong");

  reset_pc_a: assert property (@(posedge i_clk)
    i_sys_rst |=> pc_reg == RESET_VECTOR && !exec_valid_reg)
    else $error("reset did not clear the counter");

  startup_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !started |=> state_reg == st_startup && !exec_valid_reg && pc_reg == RESET_VECTOR)
    else $error("execution began before the start-up delay");

  lowb_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ar_take && i_s_axi_araddr == LOW_BYTE_ADDR |=> rdata_reg == {24'h0, $past(pc_reg[7:0])})
    else $error("low byte read wrong");

endmodule : program_counter_sequencer

/* logic/seq_pkg.sv */
// Purpose: shared constants and types of the instruction sequencer
// Assumes: one 200 MHz clock that is itself the system clock
// Notes:   byte address of a documented register is four times its index
package seq_pkg;

  localparam int unsigned PC_WIDTH        = 11;
  localparam int unsigned WORD_WIDTH      = 15;
  localparam int unsigned PHASE_COUNT     = 4;
  localparam int unsigned AXI_ADDR_WIDTH  = 8;

  // start-up delay, in system clock periods, and its cycle count
  localparam int unsigned STARTUP_DELAY_PERIOD = 1024;
  localparam int unsigned CLOCKS_PER_TSYS      = 1;
  localparam int unsigned STARTUP_CYCLES       = STARTUP_DELAY_PERIOD * CLOCKS_PER_TSYS;

  // register indices and byte addresses
  localparam logic [7:0] LOW_BYTE_INDEX = 8'h06;
  localparam logic [7:0] LOW_BYTE_ADDR  = 8'h18;
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] PC_ADDR     = 8'h08;

  localparam int unsigned CTRL_HOLD_BIT       = 0;
  localparam int unsigned STATUS_STARTED_BIT  = 0;
  localparam int unsigned STATUS_PENDING_BIT  = 1;
  localparam int unsigned STATUS_DUMMY_BIT    = 2;

  localparam logic [10:0] RESET_VECTOR  = 11'h000;
  localparam logic [10:0] USB_VECTOR    = 11'h004;
  localparam logic [10:0] TIMER0_VECTOR = 11'h008;
  localparam logic [10:0] TIMER1_VECTOR = 11'h00c;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    xfer_none,
    xfer_jump,
    xfer_call,
    xfer_ret,
    xfer_reti,
    xfer_skip,
    xfer_irq_usb,
    xfer_irq_t0,
    xfer_irq_t1
  } xfer_kind_e;

  typedef enum logic {
    st_startup,
    st_run
  } seq_state_e;

endpackage : seq_pkg

/* logic/startup_timer.sv */
// Purpose: holds off execution for the start-up delay after reset
// Assumes: counts every system clock after reset release
// Notes:   o_done stays high until the next reset
`timescale 1ns/1ps
module startup_timer #(
  parameter int unsigned CYCLES = 1024
) (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  output logic      o_done
);
  import seq_pkg::*;

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_reg;
  logic          done_reg;

  generate
    if (CYCLES < 1)
    begin : g_bad
      $error("start-up count must be at least one");
    end
  endgenerate

  assign o_done = done_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end
    else if (!done_reg)
    begin
      cnt_reg  <= cnt_reg + 1'b1;
      done_reg <= (cnt_reg == LAST);
    end
  end

  startup_len_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(done_reg) |-> $past(cnt_reg) == LAST && cnt_reg == CW'(CYCLES))
    else $error("start-up delay ended at the wrong count");

endmodule : startup_timer

/* verification/pmem_model.sv */
// Purpose: program memory model answering the sequencer's fetches
// Assumes: a word is valid LAT clocks after the fetch pulse
// Notes:   before that the data lines carry the inverted word
`timescale 1ns/1ps
module pmem_model #(
  parameter int unsigned LAT = 2
) (
  input  wire logic        i_clk,
  input  wire logic [10:0] i_addr,
  input  wire logic        i_rd,
  output logic [14:0]      o_data
);
  int unsigned age;
  logic [14:0] word;

  initial age = 0;

  // age of the current fetch, restarted by each fetch pulse
  always @(posedge i_clk)
  begin
    if (i_rd)
      age <= 1;
    else if (age != 0)
      age <= age + 1;
  end

  assign word   = {i_addr[3:0], i_addr};
  // slow memory: not yet settled lines show a different value
  assign o_data = (age >= LAT) ? word : ~word;
endmodule : pmem_model

/* verification/testbench.sv */
// Purpose: self-checking bench of the program counter sequencer
// Assumes: small start-up count, reference model run at each boundary
// Notes:   registers reached through a small AXI4-Lite master
`timescale 1ns/1ps
module testbench;
  import seq_pkg::*;
  localparam int unsigned STARTUP_SMALL = 8;
  logic        i_clk, i_sys_rst;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, phase;
  xfer_kind_e  kind, last_kind;
  logic [10:0] tgt, last_tgt, pmem_addr;
  logic [14:0] pmem_data, exec_word;
  logic        pmem_rd, exec_valid, dummy, running;
  int          n_errors, check_count, cycles;
  int          pc, ev, pend, pbyte, last_phase, mon_on;

  program_counter_sequencer #(.STARTUP(STARTUP_SMALL)) i_program_counter_sequencer (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awprot(3'h0), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
    .i_s_axi_arprot(3'h0), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .i_xfer_kind(kind), .i_xfer_target(tgt),
    .i_pmem_data(pmem_data), .o_pmem_addr(pmem_addr), .o_pmem_rd(pmem_rd),
    .o_exec_word(exec_word), .o_exec_valid(exec_valid), .o_dummy_cycle(dummy),
    .o_phase(phase), .o_running(running));

  pmem_model i_pmem_model (.i_clk(i_clk), .i_addr(pmem_addr), .i_rd(pmem_rd),
    .o_data(pmem_data));

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  // request held over n instruction boundaries, set just after phase 0
  task automatic step(input xfer_kind_e k, input logic [10:0] t, input int n);
    do
      @(posedge i_clk);
    while (phase !== 2'h0);
    kind <= k;
    tgt  <= t;
    repeat (4 * n) @(posedge i_clk);
    kind <= xfer_none;
  endtask : step

  // reference model of one instruction boundary
  task automatic boundary();
    logic [14:0] w;
    int tr;
    w  = {pc[3:0], pc[10:0]};
    tr = 1;
    case (last_kind)
      xfer_irq_usb: pc = 32'h004;
      xfer_irq_t0:  pc = 32'h008;
      xfer_irq_t1:  pc = 32'h00c;
      xfer_jump, xfer_call, xfer_ret, xfer_reti:
        if (ev) pc = last_tgt; else tr = 0;
      xfer_skip:
        if (ev) pc = (pc + 1) & 32'h7ff; else tr = 0;
      default: tr = 0;
    endcase
    if (tr || pend)
    begin
      if (!tr)
      begin
        pc   = (pc & 32'h700) | pbyte;
        pend = 0;
      end
      ev = 0;
    end
    else
    begin
      check("exec_word", exec_word, w);
      pc = (pc + 1) & 32'h7ff;
      ev = 1;
    end
    check("pmem_addr", pmem_addr, pc);
    check("exec_valid", exec_valid, ev);
    check("dummy", dummy, !ev);
  endtask : boundary

  always @(posedge i_clk)
  begin
    #1;
    if (mon_on && last_phase == 3 && phase === 2'h0)
      boundary();
    if (mon_on && phase !== last_phase[1:0])
      check("phase", phase, (last_phase + 1) % 4);
    if (mon_on)
      check("pmem_rd", pmem_rd, last_phase == 3 && phase === 2'h0);
    last_phase = phase;
    last_kind  = kind;
    last_tgt   = tgt;
  end

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      final_report();
    end
  end

  initial
  begin
    logic [1:0]  r;
    logic [31:0] d;
    int n;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    kind = xfer_none;
    tgt  = '0;
    {n_errors, check_count, cycles, pc, ev, pend, pbyte, last_phase, mon_on} = '0;
    i_sys_rst = 1'b1;
    void'($urandom(32'h1dab));
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    #1;
    check("reset pc", pmem_addr, 11'h000);
    n = 0;
    while (running !== 1'b1 && n < 100)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check("startup", n >= STARTUP_SMALL && n <= STARTUP_SMALL + 3, 1);
    @(negedge i_clk) mon_on = 1;
    repeat (12) @(posedge i_clk);
    for (int i = 1; i <= 8; i++)
    begin
      step(xfer_kind_e'(i), 11'($urandom), 1 + i % 2);
      step(xfer_none, 11'h000, 1);
    end
    for (int i = 0; i < 24; i++)
      step(xfer_kind_e'($urandom_range(8, 0)), 11'($urandom), 1);
    step(xfer_jump, 11'h5f0, 1);
    repeat (8) @(posedge i_clk);
    axi_write(8'h00, 32'h1, r);
    check("hold resp", r, 2'h0);
    repeat (6) @(posedge i_clk);
    axi_read(8'h08, d, r);
    check("pc reg", d, pc);
    axi_read(8'h18, d, r);
    check("low byte read", d, pc & 32'hff);
    pbyte = $urandom_range(255, 0);
    axi_write(8'h18, pbyte, r);
    check("low byte resp", r, 2'h0);
    pend = 1;
    axi_read(8'h04, d, r);
    check("status pending", d[1], 1'b1);
    axi_write(8'h00, 32'h0, r);
    repeat (12) @(posedge i_clk);
    // freeze the counter so the read and the model cannot straddle a boundary
    axi_write(8'h00, 32'h1, r);
    axi_read(8'h18, d, r);
    check("low byte after", d, pc & 32'hff);
    axi_read(8'h04, d, r);
    check("pending done", d[1], 1'b0);
    check("status running", d[0], 1'b1);
    axi_read(8'h40, d, r);
    check("unmapped rdata", d, 32'h0);
    check("unmapped rresp", r, 2'h2);
    axi_write(8'h40, 32'h5, r);
    check("unmapped bresp", r, 2'h2);
    repeat (8) @(posedge i_clk);
    final_report();
  end
endmodule : testbench
